// *** bench/svl_ram_model.sv ***
// Data RAM stand-in answering the load path's line reads
`timescale 1ns/1ps
`default_nettype none
module svl_ram_model (
    input  wire logic         i_clk,
    input  wire logic         i_rd,
    input  wire logic [31:0]  i_addr,
    output logic      [127:0] o_rdata
);
    logic [127:0] last_r = '0; // Last value on the bus

    // Line bytes, byte 0 in the top bits
    function automatic logic [127:0] pattern(input logic [31:0] a);
        for (int k = 0; k < 16; k++)
            pattern[127-8*k -: 8] = a[11:4] + 8'(k * 17);
    endfunction

    // Idle bus flips every cycle so no stale copy can pass
    assign o_rdata = i_rd ? pattern(i_addr) : ~last_r;

    // Remember what was shown
    always @(posedge i_clk)
        last_r <= o_rdata;
endmodule // svl_ram_model
`default_nettype wire

// *** bench/svl_top_checker.sv ***
// Assertion checker for the SIMD load path top
`timescale 1ns/1ps
`default_nettype none
module svl_top_checker #(
    parameter logic [5:0] P_COP2_LOAD_WORD_MAJOR_OPCODE_OPC = 6'h32
) (
    input wire logic                 i_clk,
    input wire logic                 i_rstn,
    input wire svl_pkg::svl_cmd_type i_cmd,
    input wire svl_pkg::svl_ctl_type i_ctl,
    input wire logic                 i_ld_valid,
    input wire logic [31:0]          i_ld_instr,
    input wire logic [31:0]          o_ram_addr,
    input wire logic                 o_ram_rd,
    input wire logic                 o_ld_done,
    input wire logic [15:0]          o_ctl_rdata,
    input wire logic [47:0]          o_acc
);
    import svl_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    logic acc_op; // Command that writes the accumulator
    assign acc_op = i_cmd.valid && (i_cmd.op inside {OP_ACCADD, OP_ACCLO});
    // Accepted load issue
    sequence ld_issue_s;
        i_ld_valid && i_ld_instr[31:26] == P_COP2_LOAD_WORD_MAJOR_OPCODE_OPC
            && i_ld_instr[15:11] <= LD_REST;
    endsequence
    // Read request, then write-back
    sequence ld_pipe_s;
        o_ram_rd ##1 o_ld_done;
    endsequence
    // Direct write of carry register, then read it
    sequence ctl_wr_s;
        i_ctl.wr && i_ctl.sel == CTL_CO && !i_cmd.valid
            ##1 !i_ctl.wr && i_ctl.sel == CTL_CO && !i_cmd.valid;
    endsequence
    ld_pipe_a: assert property (ld_issue_s |=> ld_pipe_s)
        else $error("load pipeline timing wrong");
    rd_cause_a: assert property (o_ram_rd |-> $past(i_ld_valid))
        else $error("read without issue");
    bad_opc_a: assert property (i_ld_valid
        && i_ld_instr[31:26] != P_COP2_LOAD_WORD_MAJOR_OPCODE_OPC |=> !o_ram_rd)
        else $error("foreign opcode read");
    line_addr_a: assert property (o_ram_rd |-> o_ram_addr[3:0] == 4'h0)
        else $error("unaligned line read");
    acc_hold_a: assert property (!acc_op |=> $stable(o_acc))
        else $error("accumulator changed");
    acc_part_a: assert property (i_cmd.valid && i_cmd.op == OP_ACCLO
        |=> o_acc[47:16] == $past(o_acc[47:16]))
        else $error("upper accumulator changed");
    ctl_rd_a: assert property (ctl_wr_s |=> o_ctl_rdata == $past(i_ctl.wdata, 2))
        else $error("carry register readback");
    ce_hi_a: assert property (i_ctl.sel == CTL_CE |=> o_ctl_rdata[15:8] == 8'h00)
        else $error("extension upper bits");
endmodule // svl_top_checker
bind svl_top svl_top_checker #(.P_COP2_LOAD_WORD_MAJOR_OPCODE_OPC(P_COP2_LOAD_WORD_MAJOR_OPCODE_OPC)) svl_top_checker_inst (.*);
`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench for the SIMD load path top
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import svl_pkg::*;
    localparam logic [5:0] OPC = 6'h32; // Load major opcode
    logic         i_clk, i_rstn, i_ld_valid, o_ram_rd, o_ld_done;
    svl_cmd_type  i_cmd;
    svl_ctl_type  i_ctl;
    logic [31:0]  i_ld_instr, i_ld_base, o_ram_addr;
    logic [127:0] i_ram_rdata, o_rd_data;
    logic [4:0]   i_rd_sel;
    logic [15:0]  o_ctl_rdata, seed, co, cl, cc; // Model flags
    logic [47:0]  o_acc, acc;                // Model accumulator
    logic [127:0] mv [32] = '{default: '0};  // Model registers
    int           mismatches, checks;

    svl_top #(.P_COP2_LOAD_WORD_MAJOR_OPCODE_OPC(OPC)) svl_top_inst (.*);
    svl_ram_model svl_ram_model_inst (.i_clk(i_clk), .i_rd(o_ram_rd),
        .i_addr(o_ram_addr), .o_rdata(i_ram_rdata));

    // Free-running clock, 40 ns
    initial
    begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Read a register back and compare with the model
    task automatic rd(input logic [4:0] v);
        @(posedge i_clk);
        i_rd_sel <= v;
        @(posedge i_clk);
        @(negedge i_clk);
        check(o_rd_data, mv[v]);
    endtask

    // Control access; read back one edge after
    task automatic ctl(input logic w, input logic [1:0] s,
                       input logic [15:0] d, input logic [15:0] exp);
        @(posedge i_clk);
        i_ctl <= '{w, s, d};
        @(posedge i_clk);
        i_ctl.wr <= 1'b0;
        @(posedge i_clk);
        @(negedge i_clk);
        check(128'(o_ctl_rdata), 128'(exp));
    endtask

    // Command left valid so a second call runs back to back
    task automatic cmd(input svl_op_type op, input logic bt,
                       input logic [4:0] d, input logic [4:0] s,
                       input logic [4:0] t);
        @(posedge i_clk);
        i_cmd <= '{1'b1, op, bt, d, s, t};
    endtask

    task automatic idle();
        @(posedge i_clk);
        i_cmd.valid <= 1'b0;
    endtask

    // Host issues a load; codes 6 and 7 must be ignored
    task automatic ld(input logic [4:0] sub, input logic [4:0] vt,
                      input logic [3:0] el, input logic [6:0] ofs,
                      input logic [31:0] base);
        logic [31:0] ea;
        int          sh, off;
        sh = (sub == LD_REST) ? 4 : int'(sub);
        ea = base + ({{25{ofs[6]}}, ofs} << sh);
        off = int'(ea[3:0]);
        @(posedge i_clk);
        i_ld_valid <= 1'b1;
        i_ld_instr <= {(sub == 5'h07) ? ~OPC : OPC, 5'h00, vt, sub, el, ofs};
        i_ld_base <= base;
        @(posedge i_clk);
        i_ld_valid <= 1'b0;
        @(posedge i_clk);
        @(negedge i_clk);
        check(128'(o_ld_done), 128'(sub <= LD_REST));
        if (sub > LD_REST)
            return;
        check(128'(o_ram_addr), 128'({ea[31:4], 4'h0}));
        for (int i = 0; i < 16; i++)
            if (sub == LD_REST && i <= off)
                mv[vt][127-8*(15-off+i) -: 8] = ea[11:4] + 8'(i * 17);
            else if (sub != LD_REST && i < (1 << sh) && off + i <= 15
                     && el + i <= 15)
                mv[vt][127-8*(el+i) -: 8] = ea[11:4] + 8'((off + i) * 17);
    endtask

    // Lane-wise add or subtract with carry, clamping and sticky flags
    task automatic m_add(input logic sb, input logic bt,
                         input int d, input int s, input int t);
        int a, b, r, u, g;
        g = sb ? -1 : 1;
        for (int j = 0; j < 8; j++)
        begin
            a = bt ? int'(mv[s][16*j +: 8]) : int'($signed(mv[s][16*j +: 16]));
            b = bt ? int'(mv[t][16*j +: 8]) : int'($signed(mv[t][16*j +: 16]));
            u = int'(mv[s][16*j +: 16]) + g * (int'(mv[t][16*j +: 16]) + co[j]);
            r = a + g * (b + co[j]);
            co[8+j] = co[8+j] | (a != b);
            co[j] = u[16];
            if (r > (bt ? 255 : 32767))
                cl[8+j] = 1'b1;
            if (r < (bt ? 0 : -32768))
                cl[j] = 1'b1;
            r = (r > (bt ? 255 : 32767)) ? (bt ? 255 : 32767) : r;
            r = (r < (bt ? 0 : -32768)) ? (bt ? 0 : -32768) : r;
            mv[d][16*j +: 16] = 16'(r);
        end
    endtask

    // Select keeps the smaller lane and notes it; merge obeys the note
    task automatic m_sel(input logic m, input int d, input int s, input int t);
        logic [15:0] a, b;
        for (int j = 0; j < 8; j++)
        begin
            a = mv[s][16*j +: 16];
            b = mv[t][16*j +: 16];
            if (!m)
                cc[j] = $signed(a) < $signed(b);
            mv[d][16*j +: 16] = cc[j] ? a : b;
        end
    endtask

    // Watchdog: the sequence needs about 176 cycles
    initial
    begin
        #100us;
        mismatches++;
        test_done();
    end

    // Main sequence; the bench alone steers program flow
    initial
    begin
        i_rstn = 1'b0;
        i_cmd = '0;
        i_ctl = '0;
        i_ld_valid = 1'b0;
        i_ld_instr = '0;
        i_ld_base = '0;
        i_rd_sel = '0;
        seed = 16'h0036;
        acc = '0;
        mismatches = 0;
        checks = 0;
        repeat (3) @(posedge i_clk);
        i_rstn <= 1'b1;
        for (int k = 0; k < 4; k++)
            ctl(1'b0, 2'(k), 16'h0000, 16'h0000);
        for (int n = 0; n < 24; n++)
        begin
            seed = nx(seed);
            ld(5'(n % 8), 5'(n % 4), seed[3:0], seed[10:4], {20'h0, seed[15:4]});
            rd(5'(n % 4));
        end
        co = seed;
        cl = '0;
        cc = '0;
        ctl(1'b1, CTL_CO, seed, seed);
        for (int k = 0; k < 6; k++)
        begin
            cmd((k > 3) ? (k[0] ? OP_MRG : OP_SEL) : (k[1] ? OP_SUB : OP_ADD),
                k[0] && k < 4, 5'(4 + k), 5'(2 * k[0]), 5'(2 * k[0] + 1));
            idle();
            if (k > 3)
                m_sel(k[0], 4 + k, 2 * k[0], 2 * k[0] + 1);
            else
                m_add(k[1], k[0], 4 + k, 2 * k[0], 2 * k[0] + 1);
            rd(5'(4 + k));
        end
        ctl(1'b0, CTL_CL, 16'h0000, cl);
        ctl(1'b0, CTL_CC, 16'h0000, cc);
        cmd(OP_NECLR, 1'b0, 5'd0, 5'd0, 5'd0);
        idle();
        co[15:8] = 8'h00;
        ctl(1'b0, CTL_CO, 16'h0000, co);
        cmd(OP_ACCLO, 1'b0, 5'd0, 5'd4, 5'd0);
        cmd(OP_ACCADD, 1'b0, 5'd0, 5'd4, 5'd5);
        idle();
        acc[15:0] = mv[4][15:0];
        acc = acc + 48'(int'($signed(mv[4][15:0])) * int'($signed(mv[5][15:0])));
        @(negedge i_clk);
        check(128'(o_acc), 128'(acc));
        test_done();
    end
endmodule // testbench
`default_nettype wire

// *** core/svl_align.sv ***
// Load alignment crossbar from a doubleword pair into a vector register
`timescale 1ns/1ps
`default_nettype none
module svl_align (
    input  wire logic [svl_pkg::VEC_W-1:0]  i_line,
    input  wire logic [3:0]                 i_off,
    input  wire logic [3:0]                 i_elem,
    input  wire logic [2:0]                 i_shift,
    input  wire logic                       i_rest,
    output logic      [svl_pkg::VEC_W-1:0]  o_data,
    output logic      [svl_pkg::BYTES-1:0]  o_mask
);
    import svl_pkg::*;

    // Byte j of the register is bits [127-8j -: 8], big-endian
    always_comb
    begin
        int len;
        int src;
        logic ok;
        len = 1 << i_shift;
        src = 0;
        ok = 1'b0;
        o_data = '0;
        o_mask = '0;
        for (int j = 0; j < BYTES; j++)
        begin
            if (i_rest)
            begin
                // Memory bytes 0..off land right-justified
                src = j - (15 - int'(i_off));
                ok  = (src >= 0);
            end
            else
            begin
                // Memory bytes from off on, at most 1 << shift of them and none past 15, land from the element on
                src = int'(i_off) + j - int'(i_elem);
                ok  = (j >= int'(i_elem)) &&
                      (j - int'(i_elem) < len) &&
                      (src <= 15);
            end
            // Bytes past byte 15 of the register are dropped
            if (ok)
            begin
                o_data[VEC_W-1-8*j -: 8] = i_line[VEC_W-1-8*src -: 8];
                o_mask[j] = 1'b1;
            end
        end
    end
endmodule // svl_align
`default_nettype wire

// *** core/svl_lane.sv ***
// One 16-bit lane of the SIMD datapath
`timescale 1ns/1ps
`default_nettype none
module svl_lane (
    input  wire logic [svl_pkg::LANE_W-1:0] i_a,
    input  wire logic [svl_pkg::LANE_W-1:0] i_b,
    input  wire svl_pkg::svl_op_type        i_op,
    input  wire logic                       i_byte,
    input  wire logic                       i_cin,
    input  wire logic                       i_ccin,
    output svl_pkg::svl_lane_out_type       o_out
);
    import svl_pkg::*;

    // Lane arithmetic; bytes use the low byte as unsigned
    always_comb
    begin
        logic signed [17:0] ea;
        logic signed [17:0] eb;
        logic signed [17:0] sum;
        logic        [16:0] usum;
        logic        [17:0] sat;
        ea = '0;
        eb = '0;
        sum = '0;
        usum = '0;
        sat = '0;
        o_out = '0;
        if (i_byte)
        begin
            ea = {10'h000, i_a[7:0]};
            eb = {10'h000, i_b[7:0]};
        end
        else
        begin
            ea = {{2{i_a[15]}}, i_a};
            eb = {{2{i_b[15]}}, i_b};
        end
        // Carry or borrow out of the unsigned 16-bit operation
        if (i_op == OP_SUB)
        begin
            usum = {1'b0, i_a} - {1'b0, i_b} - {16'h0000, i_cin};
            sum  = ea - eb - {17'h00000, i_cin};
        end
        else
        begin
            usum = {1'b0, i_a} + {1'b0, i_b} + {16'h0000, i_cin};
            sum  = ea + eb + {17'h00000, i_cin};
        end
        sat = svl_sat({{30{sum[17]}}, sum}, i_byte);
        // Equality on the typed operands, low byte for bytes
        o_out.ne = (ea != eb);
        o_out.ce = (ea == eb);
        case (i_op)
            OP_ADD, OP_SUB:
            begin
                o_out.res   = sat[15:0];
                o_out.clamp = sat[17:16];
                o_out.cout  = usum[16];
            end
            OP_SEL:
            begin
                // Keep the smaller operand, remember which won
                o_out.cc  = (ea < eb);
                o_out.res = (ea < eb) ? i_a : i_b;
            end
            OP_MRG:
                o_out.res = i_ccin ? i_a : i_b;
            default:
                o_out.res = i_a;
        endcase
    end
endmodule // svl_lane
`default_nettype wire

// *** core/svl_pkg.sv ***
// Constants, carriers and shared arithmetic for the SIMD load path
package svl_pkg;
    // Datapath geometry
    localparam int LANES  = 8;
    localparam int LANE_W = 16;
    localparam int VEC_W  = 128;
    localparam int BYTES  = 16;
    localparam int NREGS  = 32;
    localparam int ACC_W  = 48;

    // Load instruction field positions and widths
    localparam int OPC_LSB  = 26;
    localparam int OPC_W    = 6;
    localparam int VT_LSB   = 16;
    localparam int SUB_LSB  = 11;
    localparam int SUB_W    = 5;
    localparam int ELEM_LSB = 7;
    localparam int ELEM_W   = 4;
    localparam int OFS_W    = 7;

    // Load sub-opcode encodings
    localparam logic [4:0] LD_BYTE   = 5'h00;
    localparam logic [4:0] LD_SHORT  = 5'h01;
    localparam logic [4:0] LD_LONG   = 5'h02;
    localparam logic [4:0] LD_DOUBLE = 5'h03;
    localparam logic [4:0] LD_QUAD   = 5'h04;
    localparam logic [4:0] LD_REST   = 5'h05;

    // Control register selects
    localparam logic [1:0] CTL_CC = 2'h0;
    localparam logic [1:0] CTL_CO = 2'h1;
    localparam logic [1:0] CTL_CE = 2'h2;
    localparam logic [1:0] CTL_CL = 2'h3;

    // Reset values
    localparam logic [15:0]      FLAGS_RST = 16'h0000;
    localparam logic [ACC_W-1:0] ACC_RST   = 48'h0000_0000_0000;

    // Load latency from issue to usable result, in cycles
    localparam int LOAD_LAT = 2;

    // Saturation limits per data type
    localparam logic signed [ACC_W-1:0] SAT_U8_MAX  = 48'sh0000_0000_00ff;
    localparam logic signed [ACC_W-1:0] SAT_U8_MIN  = 48'sh0000_0000_0000;
    localparam logic signed [ACC_W-1:0] SAT_S16_MAX = 48'sh0000_0000_7fff;
    localparam logic signed [ACC_W-1:0] SAT_S16_MIN = 48'shffff_ffff_8000;

    // Computational operations
    typedef enum logic [3:0] {
        OP_NOP, OP_ADD, OP_SUB, OP_SEL, OP_MRG,
        OP_NECLR, OP_ACCADD, OP_ACCLO, OP_ACCRD
    } svl_op_type;

    // Computational command from the host core
    typedef struct packed {
        logic       valid;
        svl_op_type op;
        logic       byte_t;
        logic [4:0] vd;
        logic [4:0] vs;
        logic [4:0] vt;
    } svl_cmd_type;

    // Move-control access
    typedef struct packed {
        logic        wr;
        logic [1:0]  sel;
        logic [15:0] wdata;
    } svl_ctl_type;

    // One lane's result and flags
    typedef struct packed {
        logic [15:0] res;
        logic        cout;
        logic        ne;
        logic        cc;
        logic        ce;
        logic [1:0]  clamp;
    } svl_lane_out_type;

    // Clamp to type range: {high hit, low hit, 16-bit value}
    function automatic logic [17:0] svl_sat(
        input logic signed [ACC_W-1:0] v,
        input logic                    byte_t);
        logic signed [ACC_W-1:0] mx;
        logic signed [ACC_W-1:0] mn;
        mx = byte_t ? SAT_U8_MAX : SAT_S16_MAX;
        mn = byte_t ? SAT_U8_MIN : SAT_S16_MIN;
        if (v > mx)
            return {2'b10, mx[15:0]};
        if (v < mn)
            return {2'b01, mn[15:0]};
        return {2'b00, v[15:0]};
    endfunction
endpackage

// *** core/svl_top.sv ***
// SIMD coprocessor: register file, lane flags, accumulator, load path
`timescale 1ns/1ps
`default_nettype none
module svl_top #(
    parameter int         P_LANES    = svl_pkg::LANES,
    parameter int         P_LANE_W   = svl_pkg::LANE_W,
    parameter logic [5:0] P_COP2_LOAD_WORD_MAJOR_OPCODE_OPC = 6'h32  // Major opcode of loads
) (
    input  wire logic                        i_clk,
    input  wire logic                        i_rstn,
    input  wire svl_pkg::svl_cmd_type        i_cmd,
    input  wire svl_pkg::svl_ctl_type        i_ctl,
    input  wire logic                        i_ld_valid,
    input  wire logic [31:0]                 i_ld_instr,
    input  wire logic [31:0]                 i_ld_base,
    input  wire logic [svl_pkg::VEC_W-1:0]   i_ram_rdata,
    input  wire logic [4:0]                  i_rd_sel,
    output logic      [31:0]                 o_ram_addr,
    output logic                             o_ram_rd,
    output logic                             o_ld_done,
    output logic      [15:0]                 o_ctl_rdata,
    output logic      [svl_pkg::VEC_W-1:0]   o_rd_data,
    output logic      [svl_pkg::ACC_W-1:0]   o_acc
);
    import svl_pkg::*;

    // Lanes must tile the 128-bit vector exactly
    if (P_LANES * P_LANE_W != VEC_W || P_LANE_W != LANE_W)
    begin : g_chk
        $error("svl_top: lane geometry does not fill 128 bits");
    end

    // Load held between issue and write-back
    typedef struct packed {
        logic       valid;
        logic [4:0] vt;
        logic [3:0] elem;
        logic [2:0] shift;
        logic       rest;
        logic [3:0] off;
    } svl_ld_type;

    // Whole module state
    typedef struct packed {
        logic [NREGS-1:0][VEC_W-1:0] vr;     // Vector registers
        logic [15:0]                 cc;     // Compare code
        logic [15:0]                 co;     // Carry and not-equal
        logic [7:0]                  ce;     // Compare extension
        logic [15:0]                 cl;     // Clamp flags
        logic [ACC_W-1:0]            acc;    // Accumulator
        svl_ld_type                  ld;     // Load in flight
        logic [31:0]                 ram_addr;
        logic                        ram_rd;
        logic                        ld_done;
        logic [15:0]                 ctl_rdata;
        logic [VEC_W-1:0]            rd_data;
    } svl_state_type;

    svl_state_type                       s_r;       // Registered state
    svl_state_type                       s_nxt;     // Next state
    logic          [VEC_W-1:0]           va;        // Source vector a
    logic          [VEC_W-1:0]           vb;        // Source vector b
    svl_lane_out_type [P_LANES-1:0]      lo;        // Lane results
    logic          [VEC_W-1:0]           adata;     // Aligned load bytes
    logic          [BYTES-1:0]           amask;     // Bytes to write

    // Operands come straight from the file; writes land next edge
    assign va = s_r.vr[i_cmd.vs];
    assign vb = s_r.vr[i_cmd.vt];

    // Eight identical lanes working on one vector
    for (genvar j = 0; j < P_LANES; j++)
    begin : g_lane
        svl_lane u_lane (
            .i_a    (va[j*LANE_W +: LANE_W]),
            .i_b    (vb[j*LANE_W +: LANE_W]),
            .i_op   (i_cmd.op),
            .i_byte (i_cmd.byte_t),
            .i_cin  (s_r.co[j]),
            .i_ccin (s_r.cc[j]),
            .o_out  (lo[j])
        );
    end

    // Crossbar for the load waiting on RAM data
    svl_align u_align (
        .i_line  (i_ram_rdata),
        .i_off   (s_r.ld.off),
        .i_elem  (s_r.ld.elem),
        .i_shift (s_r.ld.shift),
        .i_rest  (s_r.ld.rest),
        .o_data  (adata),
        .o_mask  (amask)
    );

    // Next-state logic for every register of the block
    always_comb
    begin
        logic [31:0]          ofs;
        logic [31:0]          ea;
        logic [2:0]           sh;
        logic                 known;
        logic                 rest;
        logic signed [31:0]   prod;
        logic [17:0]          sat;
        logic [VEC_W-1:0]     wres;
        ofs   = '0;
        ea    = '0;
        sh    = '0;
        known = 1'b0;
        rest  = 1'b0;
        prod  = '0;
        sat   = '0;
        wres  = '0;
        s_nxt = s_r;
        s_nxt.ram_rd   = 1'b0;
        s_nxt.ld_done  = 1'b0;
        s_nxt.ld.valid = 1'b0;

        // Move-control writes go first so hardware sets win
        if (i_ctl.wr)
        begin
            case (i_ctl.sel)
                CTL_CC:
                    s_nxt.cc = i_ctl.wdata;
                CTL_CO:
                    s_nxt.co = i_ctl.wdata;
                CTL_CE:
                    s_nxt.ce = i_ctl.wdata[7:0];
                default:
                    s_nxt.cl = i_ctl.wdata;
            endcase
        end

        // Gather lane results into one vector
        for (int j = 0; j < P_LANES; j++)
        begin
            wres[j*LANE_W +: LANE_W] = lo[j].res;
        end

        // Computational instructions
        if (i_cmd.valid)
        begin
            case (i_cmd.op)
                OP_ADD, OP_SUB:
                begin
                    s_nxt.vr[i_cmd.vd] = wres;
                    for (int j = 0; j < P_LANES; j++)
                    begin
                        // Carry out replaces, not-equal accumulates
                        s_nxt.co[j] = lo[j].cout;
                        s_nxt.co[LANES+j] =
                            s_nxt.co[LANES+j] | lo[j].ne;
                        s_nxt.cl[j] =
                            s_nxt.cl[j] | lo[j].clamp[0];
                        s_nxt.cl[LANES+j] =
                            s_nxt.cl[LANES+j] | lo[j].clamp[1];
                    end
                end
                OP_SEL:
                begin
                    s_nxt.vr[i_cmd.vd] = wres;
                    for (int j = 0; j < P_LANES; j++)
                    begin
                        s_nxt.cc[j] = lo[j].cc;
                        s_nxt.ce[j] = lo[j].ce;
                    end
                end
                OP_MRG:
                    s_nxt.vr[i_cmd.vd] = wres;
                OP_NECLR:
                    // Sticky bits drop here, on a direct write of CO, or on reset
                    s_nxt.co[15:8] = 8'h00;
                OP_ACCADD:
                begin
                    // Multiply-accumulate on lane 0; the next
                    // instruction sees the sum without a stall
                    prod = $signed(va[LANE_W-1:0]) *
                           $signed(vb[LANE_W-1:0]);
                    s_nxt.acc = s_r.acc +
                                {{16{prod[31]}}, prod};
                end
                OP_ACCLO:
                    // Partial update, upper bits keep value
                    s_nxt.acc[LANE_W-1:0] = va[LANE_W-1:0];
                OP_ACCRD:
                begin
                    // Clamp accumulator into every lane
                    sat = svl_sat(s_r.acc, i_cmd.byte_t);
                    for (int j = 0; j < P_LANES; j++)
                    begin
                        s_nxt.vr[i_cmd.vd][j*LANE_W +: LANE_W] =
                            sat[15:0];
                        s_nxt.cl[j] = s_nxt.cl[j] | sat[16];
                        s_nxt.cl[LANES+j] =
                            s_nxt.cl[LANES+j] | sat[17];
                    end
                end
                default:
                    // No-op leaves all state alone
                    s_nxt.acc = s_r.acc;
            endcase
        end

        // Load write-back; load bytes override a same-cycle compute
        if (s_r.ld.valid)
        begin
            for (int b = 0; b < BYTES; b++)
            begin
                if (amask[b])
                begin
                    s_nxt.vr[s_r.ld.vt][VEC_W-1-8*b -: 8] =
                        adata[VEC_W-1-8*b -: 8];
                end
            end
            s_nxt.ld_done = 1'b1;
        end

        // Load issue: only the coprocessor load opcode is taken
        if (i_ld_valid &&
            i_ld_instr[OPC_LSB +: OPC_W] == P_COP2_LOAD_WORD_MAJOR_OPCODE_OPC)
        begin
            case (i_ld_instr[SUB_LSB +: SUB_W])
                LD_BYTE:
                begin
                    sh = 3'd0;
                    known = 1'b1;
                end
                LD_SHORT:
                begin
                    sh = 3'd1;
                    known = 1'b1;
                end
                LD_LONG:
                begin
                    sh = 3'd2;
                    known = 1'b1;
                end
                LD_DOUBLE:
                begin
                    sh = 3'd3;
                    known = 1'b1;
                end
                LD_QUAD:
                begin
                    sh = 3'd4;
                    known = 1'b1;
                end
                LD_REST:
                begin
                    sh = 3'd4;
                    rest = 1'b1;
                    known = 1'b1;
                end
                default:
                    // Unknown sub-opcode is dropped
                    known = 1'b0;
            endcase
            // Sign-extended offset weighted by item size
            ofs = {{25{i_ld_instr[OFS_W-1]}},
                   i_ld_instr[OFS_W-1:0]};
            ea = i_ld_base + (ofs << sh);
            s_nxt.ld.valid = known;
            s_nxt.ld.vt    = i_ld_instr[VT_LSB +: 5];
            s_nxt.ld.elem  = i_ld_instr[ELEM_LSB +: ELEM_W];
            s_nxt.ld.shift = sh;
            s_nxt.ld.rest  = rest;
            s_nxt.ld.off   = ea[3:0];
            if (known)
            begin
                // Pair of doublewords at the aligned line
                s_nxt.ram_addr = {ea[31:4], 4'h0};
                s_nxt.ram_rd   = 1'b1;
            end
        end

        // Registered read-back of the selected control register
        case (i_ctl.sel)
            CTL_CC:
                s_nxt.ctl_rdata = s_r.cc;
            CTL_CO:
                s_nxt.ctl_rdata = s_r.co;
            CTL_CE:
                s_nxt.ctl_rdata = {8'h00, s_r.ce};
            default:
                s_nxt.ctl_rdata = s_r.cl;
        endcase

        // Store-side read port into the register file
        s_nxt.rd_data = s_r.vr[i_rd_sel];
    end

    // State register; whole file clears on reset
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            s_r     <= '0;
            s_r.cc  <= FLAGS_RST;
            s_r.co  <= FLAGS_RST;
            s_r.ce  <= FLAGS_RST[7:0];
            s_r.cl  <= FLAGS_RST;
            s_r.acc <= ACC_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state flops
    assign o_ram_addr  = s_r.ram_addr;
    assign o_ram_rd    = s_r.ram_rd;
    assign o_ld_done   = s_r.ld_done;
    assign o_ctl_rdata = s_r.ctl_rdata;
    assign o_rd_data   = s_r.rd_data;
    assign o_acc       = s_r.acc;
endmodule // svl_top
`default_nettype wire
